// >>> dv/testbench.sv
// Self-checking testbench for the motor start-up configuration register.
module testbench import mscd_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	logic         ref_clk = 1'b0, rst_n = 1'b0, clk_en = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
	logic         rd_d = 1'b0;
	logic  [7:0]  reg_addr = 8'h00;
	logic  [31:0] reg_wdata = 32'h00000000, reg_rdata, cur = 32'h00000000, w;
	logic  [63:0] e, expq[$];
	mscd_method_t startup_method_sel;
	logic  [15:0] align_ramp_rate, align_time_ms, probe_rate_hz, first_cycle_rate;
	logic  [3:0]  align_current_limit_sel, probe_current_limit_sel;
	logic  [6:0]  probe_lead_angle_deg;
	logic  [2:0]  probe_runs;
	logic         probe_release_sel, parity_bit, cfg_unsupported;
	int           failures = 0, total_checks = 0, cycles = 0;
	mscd_startup_cfg uut (.ref_clk, .rst_n, .clk_en, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
		.reg_rdata, .startup_method_sel, .align_ramp_rate, .align_time_ms,
		.align_current_limit_sel, .probe_current_limit_sel, .probe_rate_hz, .probe_release_sel,
		.probe_lead_angle_deg, .probe_runs, .first_cycle_rate, .parity_bit, .cfg_unsupported);
	////////////////////////////////////////////////////////////////////////////////////////////
	task automatic check(logic [127:0] seen, logic [127:0] want);
		total_checks++;
		if (seen !== want) begin
			failures++;
			$display("BAD t=%0t seen=%h want=%h", $time, seen, want);
		end
	endtask : check
	task automatic final_report();
		$display("checks=%0d failures=%0d", total_checks, failures);
		if (failures == 0 && total_checks > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask : final_report
	// Expected decode of a register word, in the order of the output concatenation below.
	function automatic logic [86:0] dec(logic [31:0] v);
		return {v[30:29], MSCD_RAMP_TBL[v[28:25]], MSCD_ALIGN_T_TBL[v[24:21]], v[20:17],
			(v[13:10] < 4'h2) ? 4'h0 : v[13:10], MSCD_PROBE_F_TBL[v[16:14]], v[9:8] == 2'h1,
			7'(30 * v[7:6]), 3'(v[5:4]) + 3'h1, MSCD_FIRST_TBL[v[3:0]], v[31],
			v[20:17] == 4'h0 || v[13:10] < 4'h2 || v[9:8] > 2'h1 || v[3:0] == 4'hA};
	endfunction : dec
	// One bus cycle; every input except ref_clk and rst_n is assigned once per edge so back-to-back calls stay clean.
	task automatic op(logic wr, logic rd, logic en, logic [7:0] a, logic [31:0] d);
		reg_wr <= wr;
		reg_rd <= rd;
		clk_en <= en;
		reg_addr <= a;
		reg_wdata <= d;
		if (rd && en) expq.push_back({cur, (a == MSCD_CFG_OFS) ? cur : 32'h00000000});
		if (wr && en && a == MSCD_CFG_OFS) cur = d;
		@(posedge ref_clk);
	endtask : op
	////////////////////////////////////////////////////////////////////////////////////////////
	always #2 ref_clk = ~ref_clk;
	always @(posedge ref_clk) begin
		cycles <= cycles + 1;
		if (cycles == 3000) begin
			failures++;
			final_report();
		end
	end
	// Read data stand only in the cycle after the read, so the note is taken exactly then.
	always @(posedge ref_clk) begin
		rd_d <= reg_rd & clk_en & rst_n;
		if (rd_d) begin
			e = expq.pop_front();
			check(reg_rdata, e[31:0]);
			check({startup_method_sel, align_ramp_rate, align_time_ms, align_current_limit_sel,
				probe_current_limit_sel, probe_rate_hz, probe_release_sel, probe_lead_angle_deg,
				probe_runs, first_cycle_rate, parity_bit, cfg_unsupported}, dec(e[63:32]));
		end else if (cycles > 12) begin
			check(reg_rdata, 32'h00000000);
		end
	end
	initial begin
		w = $urandom(14);
		repeat (12) @(posedge ref_clk);
		rst_n <= 1'b1;
		op(1'b0, 1'b1, 1'b1, MSCD_CFG_OFS, 32'h00000000);
		for (int i = 0; i < 16; i++) begin
			w = {1'($urandom), i[1:0], i[3:0], i[3:0], i[3:0], i[2:0], i[3:0], i[1:0], i[1:0],
				i[1:0], i[3:0]};
			op(1'b1, 1'b0, 1'b1, MSCD_CFG_OFS, w);
			op(1'b0, 1'b1, 1'b1, MSCD_CFG_OFS, 32'h00000000);
		end
		op(1'b1, 1'b0, 1'b1, 8'h83, ~cur);
		op(1'b0, 1'b1, 1'b1, 8'h83, 32'h00000000);
		op(1'b1, 1'b1 ^ 1'b1, 1'b0, MSCD_CFG_OFS, $urandom);
		op(1'b0, 1'b1, 1'b1, MSCD_CFG_OFS, 32'h00000000);
		op(1'b1, 1'b0, 1'b1, MSCD_CFG_OFS, $urandom);
		op(1'b0, 1'b0, 1'b1, 8'h00, 32'h00000000);
		rst_n <= 1'b0;
		@(posedge ref_clk);
		rst_n <= 1'b1;
		cur = 32'h00000000;
		op(1'b0, 1'b1, 1'b1, MSCD_CFG_OFS, 32'h00000000);
		op(1'b0, 1'b0, 1'b1, 8'h00, 32'h00000000);
		op(1'b0, 1'b0, 1'b1, 8'h00, 32'h00000000);
		final_report();
	end
endmodule : testbench

// >>> rtl/mscd_pkg.sv
// Package of constants and types for the motor start-up configuration register.
package mscd_pkg;

	localparam logic [7:0]  MSCD_CFG_OFS       = 8'h82;
	localparam logic [31:0] MSCD_CFG_RST       = 32'h00000000;
	localparam logic [31:0] MSCD_WR_MASK       = 32'hFFFFFFFF;
	localparam int          MSCD_PARITY_POS    = 31;
	localparam int          MSCD_METHOD_LSB    = 29;
	localparam int          MSCD_RAMP_LSB      = 25;
	localparam int          MSCD_ALIGN_T_LSB   = 21;
	localparam int          MSCD_ALIGN_I_LSB   = 17;
	localparam int          MSCD_PROBE_F_LSB   = 14;
	localparam int          MSCD_PROBE_I_LSB   = 10;
	localparam int          MSCD_RELEASE_LSB   = 8;
	localparam int          MSCD_LEAD_LSB      = 6;
	localparam int          MSCD_REPEAT_LSB    = 4;
	localparam int          MSCD_FIRST_LSB     = 0;
	localparam logic [3:0]  MSCD_PROBE_I_MIN   = 4'h2;
	localparam logic [3:0]  MSCD_FIRST_UNDEF   = 4'hA;
	localparam logic [1:0]  MSCD_RELEASE_MAX   = 2'h1;

	typedef enum logic [1:0] {
		MSCD_SINGLE_ALIGN = 2'h0,
		MSCD_DOUBLE_ALIGN = 2'h1,
		MSCD_PROBE_START  = 2'h2,
		MSCD_SLOW_FIRST   = 2'h3
	} mscd_method_t;

	typedef struct packed {
		logic [31:0] cfg;
		logic [31:0] rdata;
	} mscd_state_t;

	// Align ramp rate in tenths of V/s.
	localparam logic [15:0] MSCD_RAMP_TBL [16] = '{
		16'h0001, 16'h0002, 16'h0005, 16'h000A, 16'h0019, 16'h0032, 16'h004B, 16'h0064,
		16'h00FA, 16'h01F4, 16'h02EE, 16'h03E8, 16'h09C4, 16'h1388, 16'h1D4C, 16'h2710};
	// Align time in ms.
	localparam logic [15:0] MSCD_ALIGN_T_TBL [16] = '{
		16'h0005, 16'h000A, 16'h0019, 16'h0032, 16'h004B, 16'h0064, 16'h00C8, 16'h0190,
		16'h0258, 16'h0320, 16'h03E8, 16'h07D0, 16'h0FA0, 16'h1770, 16'h1F40, 16'h2710};
	// Probe pulse rate in Hz.
	localparam logic [15:0] MSCD_PROBE_F_TBL [8] = '{
		16'h0032, 16'h0064, 16'h00FA, 16'h01F4, 16'h03E8, 16'h07D0, 16'h1388, 16'h2710};
	// First-cycle rate in hundredths of Hz; code A has no value and reads zero.
	localparam logic [15:0] MSCD_FIRST_TBL [16] = '{
		16'h0005, 16'h000A, 16'h0019, 16'h0032, 16'h0064, 16'h00C8, 16'h012C, 16'h01F4,
		16'h03E8, 16'h05DC, 16'h0000, 16'h09C4, 16'h1388, 16'h2710, 16'h3A98, 16'h4E20};

endpackage : mscd_pkg

// >>> rtl/mscd_startup_cfg.sv
// Start-up configuration register with decoded physical settings.
module mscd_startup_cfg
	import mscd_pkg::*;
(
	input  wire logic        ref_clk,
	input  wire logic        rst_n,
	input  wire logic        clk_en,
	input  wire logic [7:0]  reg_addr,
	input  wire logic [31:0] reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic      [31:0] reg_rdata,
	output mscd_method_t     startup_method_sel,
	output logic      [15:0] align_ramp_rate,
	output logic      [15:0] align_time_ms,
	output logic      [3:0]  align_current_limit_sel,
	output logic      [3:0]  probe_current_limit_sel,
	output logic      [15:0] probe_rate_hz,
	output logic             probe_release_sel,
	output logic      [6:0]  probe_lead_angle_deg,
	output logic      [2:0]  probe_runs,
	output logic      [15:0] first_cycle_rate,
	output logic             parity_bit,
	output logic             cfg_unsupported
);

	////////////////////////////////////////////////////////////////////////////////
	// State.

	mscd_state_t state_ff;
	mscd_state_t nxt_state;
	logic        sel;
	logic [3:0]  ai;
	logic [3:0]  pi;
	logic [1:0]  rel;
	logic [3:0]  fc;

	assign sel = (reg_addr == MSCD_CFG_OFS);

	always_comb begin
		nxt_state = state_ff;
		if (reg_wr && sel) begin
			nxt_state.cfg = reg_wdata & MSCD_WR_MASK;
		end
		// Unmapped reads return zero.
		nxt_state.rdata = (reg_rd && sel) ? state_ff.cfg : 32'h00000000;
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			state_ff <= '{cfg: MSCD_CFG_RST, rdata: 32'h00000000};
		end else if (clk_en) begin
			state_ff <= nxt_state;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Field decode. Reserved codes still store, but decode to safe zero values.

	assign reg_rdata  = state_ff.rdata;
	assign parity_bit = state_ff.cfg[MSCD_PARITY_POS];
	assign ai  = state_ff.cfg[MSCD_ALIGN_I_LSB +: 4];
	assign pi  = state_ff.cfg[MSCD_PROBE_I_LSB +: 4];
	assign rel = state_ff.cfg[MSCD_RELEASE_LSB +: 2];
	assign fc  = state_ff.cfg[MSCD_FIRST_LSB +: 4];

	assign startup_method_sel      = mscd_method_t'(state_ff.cfg[MSCD_METHOD_LSB +: 2]);
	assign align_ramp_rate         = MSCD_RAMP_TBL[state_ff.cfg[MSCD_RAMP_LSB +: 4]];
	assign align_time_ms           = MSCD_ALIGN_T_TBL[state_ff.cfg[MSCD_ALIGN_T_LSB +: 4]];
	assign align_current_limit_sel = ai;
	assign probe_rate_hz           = MSCD_PROBE_F_TBL[state_ff.cfg[MSCD_PROBE_F_LSB +: 3]];
	assign probe_current_limit_sel = (pi < MSCD_PROBE_I_MIN) ? 4'h0 : pi;
	assign probe_release_sel       = rel[0] & (rel <= MSCD_RELEASE_MAX);
	assign probe_lead_angle_deg    = 7'(30 * state_ff.cfg[MSCD_LEAD_LSB +: 2]);
	assign probe_runs              = 3'(state_ff.cfg[MSCD_REPEAT_LSB +: 2]) + 3'h1;
	assign first_cycle_rate        = MSCD_FIRST_TBL[fc];
	// Flags any reserved code so the sequencer can refuse to start.
	assign cfg_unsupported = (ai == 4'h0) || (pi < MSCD_PROBE_I_MIN)
		|| (rel > MSCD_RELEASE_MAX) || (fc == MSCD_FIRST_UNDEF);

	////////////////////////////////////////////////////////////////////////////////
	// Checks.

	chk_write_store: assert property (@(posedge ref_clk) disable iff (!rst_n)
		clk_en && reg_wr && sel |=> state_ff.cfg == $past(reg_wdata))
		else $error("Register did not store written word.");
	chk_read_data: assert property (@(posedge ref_clk) disable iff (!rst_n)
		clk_en && reg_rd && sel && !reg_wr |=> reg_rdata == state_ff.cfg)
		else $error("Read data does not match register.");
	chk_unmapped_rd: assert property (@(posedge ref_clk) disable iff (!rst_n)
		clk_en && reg_rd && !sel |=> reg_rdata == 32'h00000000)
		else $error("Unmapped read not zero.");
	chk_method_field: assert property (@(posedge ref_clk) disable iff (!rst_n)
		startup_method_sel == mscd_method_t'(state_ff.cfg[30:29]))
		else $error("Method decode wrong.");
	chk_probe_reserved: assert property (@(posedge ref_clk) disable iff (!rst_n)
		pi < 4'h2 |-> probe_current_limit_sel == 4'h0 && cfg_unsupported)
		else $error("Reserved probe limit not flagged.");
	chk_release_tri: assert property (@(posedge ref_clk) disable iff (!rst_n)
		probe_release_sel |-> rel == 2'h1)
		else $error("Tristate release on wrong code.");
	chk_runs_count: assert property (@(posedge ref_clk) disable iff (!rst_n)
		probe_runs == 3'(state_ff.cfg[5:4]) + 3'h1)
		else $error("Probe run count wrong.");
	chk_first_undef: assert property (@(posedge ref_clk) disable iff (!rst_n)
		fc == 4'hA |-> first_cycle_rate == 16'h0000 && cfg_unsupported)
		else $error("Undefined first-cycle code not flagged.");
	chk_reset_zero: assert property (@(posedge ref_clk)
		!rst_n |=> state_ff.cfg == 32'h00000000)
		else $error("Register not zero after reset.");
	chk_ramp_decode: assert property (@(posedge ref_clk) disable iff (!rst_n)
		align_ramp_rate == MSCD_RAMP_TBL[state_ff.cfg[28:25]])
		else $error("Align ramp decode wrong.");
	chk_align_time: assert property (@(posedge ref_clk) disable iff (!rst_n)
		align_time_ms == MSCD_ALIGN_T_TBL[state_ff.cfg[24:21]])
		else $error("Align time decode wrong.");
	chk_align_limit: assert property (@(posedge ref_clk) disable iff (!rst_n)
		state_ff.cfg[20:17] == 4'h0 |-> cfg_unsupported)
		else $error("Reserved align limit not flagged.");
	chk_probe_rate: assert property (@(posedge ref_clk) disable iff (!rst_n)
		probe_rate_hz == MSCD_PROBE_F_TBL[state_ff.cfg[16:14]])
		else $error("Probe rate decode wrong.");
	chk_lead_angle: assert property (@(posedge ref_clk) disable iff (!rst_n)
		probe_lead_angle_deg == 7'(30 * state_ff.cfg[7:6]))
		else $error("Lead angle decode wrong.");
	chk_frozen_cfg: assert property (@(posedge ref_clk) disable iff (!rst_n)
		!clk_en |=> $stable(state_ff.cfg))
		else $error("Register changed while clock enable low.");

	cov_write_probe: cover property (@(posedge ref_clk)
		reg_wr && sel && reg_wdata[30:29] == 2'h2);
	cov_read_back: cover property (@(posedge ref_clk) reg_wr && sel ##1 reg_rd && sel);
	cov_unsupported: cover property (@(posedge ref_clk) cfg_unsupported && rst_n);
	cov_frozen_write: cover property (@(posedge ref_clk) rst_n && !clk_en && reg_wr && sel);

endmodule : mscd_startup_cfg
